// ### rtl/mcx_pkg.sv
// package: constants, opcode classes and carriers for the instruction executor
package mcx_pkg;

  localparam int unsigned DATA_W   = 8;
  localparam int unsigned PC_W     = 12;

  // data-space locations of the short-direct registers
  localparam logic [7:0] ADDR_X    = 8'h80;
  localparam logic [7:0] ADDR_Y    = 8'h81;
  localparam logic [7:0] ADDR_V    = 8'h82;
  localparam logic [7:0] ADDR_W    = 8'h83;

  // instruction cycle counts
  localparam logic [2:0] CYC_ALU   = 3'h4;
  localparam logic [2:0] CYC_REL   = 3'h2;
  localparam logic [2:0] CYC_BTB   = 3'h5;
  localparam logic [2:0] CYC_BIT   = 3'h4;
  localparam logic [2:0] CYC_JMP   = 3'h4;
  localparam logic [2:0] CYC_CTL   = 3'h2;

  // reset values
  localparam logic [11:0] PC_RST   = 12'h000;
  localparam logic [7:0]  ACC_RST  = 8'h00;

  // opcode field positions
  localparam int unsigned IND_SEL_BIT = 4;
  localparam int unsigned BIT_NUM_LSB = 5;

  // decoded instruction class; opcode table is a lookup in the core
  typedef enum logic [4:0] {
    MCX_OP_NOP      = 5'h00,
    MCX_OP_ADD      = 5'h01,
    MCX_OP_AND      = 5'h02,
    MCX_OP_CMP      = 5'h03,
    MCX_OP_SUB      = 5'h04,
    MCX_OP_CLR      = 5'h05,
    MCX_OP_DEC      = 5'h06,
    MCX_OP_INC      = 5'h07,
    MCX_OP_COM      = 5'h08,
    MCX_OP_RLC      = 5'h09,
    MCX_OP_SLA      = 5'h0A,
    MCX_OP_BR_C     = 5'h0B,
    MCX_OP_BR_NC    = 5'h0C,
    MCX_OP_BR_Z     = 5'h0D,
    MCX_OP_BR_NZ    = 5'h0E,
    MCX_OP_BT_CLR   = 5'h0F,
    MCX_OP_BT_SET   = 5'h10,
    MCX_OP_BSET     = 5'h11,
    MCX_OP_BCLR     = 5'h12,
    MCX_OP_JP       = 5'h13,
    MCX_OP_CALL     = 5'h14,
    MCX_OP_RET      = 5'h15,
    MCX_OP_RETURN_FROM_INTERRUPT     = 5'h16,
    MCX_OP_STOP     = 5'h17,
    MCX_OP_WAIT     = 5'h18
  } mcx_op_e;

  // operand source
  typedef enum logic [2:0] {
    MCX_SRC_NONE = 3'h0,
    MCX_SRC_IMM  = 3'h1,
    MCX_SRC_DIR  = 3'h2,
    MCX_SRC_IND  = 3'h3,
    MCX_SRC_SD   = 3'h4,
    MCX_SRC_ACC  = 3'h5
  } mcx_src_e;

  // one decoded instruction handed to the core
  typedef struct packed {
    mcx_op_e    op;
    mcx_src_e   src;
    logic [1:0] nbytes;
    logic [2:0] cycles;
  } mcx_dec_s;

  // request toward data space
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mcx_dreq_s;

  // flags returned by return-from-interrupt
  typedef struct packed {
    logic z;
    logic c;
  } mcx_flags_s;

endpackage

// ### rtl/mcx_decode.sv
// decoded-class table: opcode class, operand source, length and cycle count
`timescale 1ns/1ps
`default_nettype none
module mcx_decode (
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire mcx_pkg::mcx_op_e  op_in,
  input  wire mcx_pkg::mcx_src_e src_in,
  input  wire logic              watchdog_sel,
  output mcx_pkg::mcx_dec_s      dec_out
);

  mcx_pkg::mcx_dec_s dec_reg;
  mcx_pkg::mcx_dec_s dec_next;

  always_comb begin
    dec_next.op     = op_in;
    dec_next.src    = src_in;
    dec_next.nbytes = 2'h1;
    dec_next.cycles = mcx_pkg::CYC_CTL;
    case (op_in)
      mcx_pkg::MCX_OP_ADD, mcx_pkg::MCX_OP_AND, mcx_pkg::MCX_OP_CMP, mcx_pkg::MCX_OP_SUB,
      mcx_pkg::MCX_OP_DEC, mcx_pkg::MCX_OP_INC, mcx_pkg::MCX_OP_COM, mcx_pkg::MCX_OP_RLC,
      mcx_pkg::MCX_OP_SLA: begin
        dec_next.cycles = mcx_pkg::CYC_ALU;
        // accumulator forms of inc, dec and shift carry a second byte
        dec_next.nbytes = (src_in == mcx_pkg::MCX_SRC_IMM || src_in == mcx_pkg::MCX_SRC_DIR ||
                           (src_in == mcx_pkg::MCX_SRC_ACC &&
                            op_in inside {mcx_pkg::MCX_OP_DEC, mcx_pkg::MCX_OP_INC, mcx_pkg::MCX_OP_SLA}))
                          ? 2'h2 : 2'h1;
      end
      mcx_pkg::MCX_OP_CLR: begin
        dec_next.cycles = mcx_pkg::CYC_ALU;
        dec_next.nbytes = (src_in == mcx_pkg::MCX_SRC_DIR) ? 2'h3 : 2'h2;
      end
      mcx_pkg::MCX_OP_BR_C, mcx_pkg::MCX_OP_BR_NC, mcx_pkg::MCX_OP_BR_Z, mcx_pkg::MCX_OP_BR_NZ: begin
        dec_next.cycles = mcx_pkg::CYC_REL;
      end
      mcx_pkg::MCX_OP_BT_CLR, mcx_pkg::MCX_OP_BT_SET: begin
        dec_next.cycles = mcx_pkg::CYC_BTB;
        dec_next.nbytes = 2'h3;
      end
      mcx_pkg::MCX_OP_BSET, mcx_pkg::MCX_OP_BCLR: begin
        dec_next.cycles = mcx_pkg::CYC_BIT;
        dec_next.nbytes = 2'h2;
      end
      mcx_pkg::MCX_OP_JP, mcx_pkg::MCX_OP_CALL: begin
        dec_next.cycles = mcx_pkg::CYC_JMP;
        dec_next.nbytes = 2'h2;
      end
      mcx_pkg::MCX_OP_STOP: begin
        // stop is demoted to wait while the watchdog is selected
        if (watchdog_sel) begin
          dec_next.op = mcx_pkg::MCX_OP_WAIT;
        end
      end
      default: begin
        dec_next.cycles = mcx_pkg::CYC_CTL;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dec_reg <= '{op: mcx_pkg::MCX_OP_NOP, src: mcx_pkg::MCX_SRC_NONE, nbytes: 2'h1, cycles: mcx_pkg::CYC_CTL};
    end else begin
      dec_reg <= dec_next;
    end
  end

  assign dec_out = dec_reg;

endmodule
`default_nettype wire

// ### rtl/mcx_exec.sv
// instruction executor: operand fetch, ALU, flags, branch and jump targets
`timescale 1ns/1ps
`default_nettype none
module mcx_exec (
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  input  wire logic               start,
  input  wire mcx_pkg::mcx_op_e   op_in,
  input  wire mcx_pkg::mcx_src_e  src_in,
  input  wire logic [7:0]         opcode,
  input  wire logic [7:0]         byte2,
  input  wire logic [7:0]         byte3,
  input  wire logic [11:0]        pc_in,
  input  wire logic [1:0]         sd_sel,
  input  wire logic [7:0]         x_val,
  input  wire logic [7:0]         y_val,
  input  wire logic [7:0]         mem_rdata,
  input  wire mcx_pkg::mcx_flags_s return_from_interrupt_flags,
  input  wire logic               watchdog_sel,
  output logic [7:0]              acc,
  output logic                    flag_z,
  output logic                    flag_c,
  output logic [11:0]             pc_next,
  output mcx_pkg::mcx_dreq_s      dreq,
  output logic                    push_ret,
  output logic                    pop_ret,
  output logic                    wait_req,
  output logic                    stop_req,
  output logic                    done,
  output mcx_pkg::mcx_dec_s       dec_info
);

  typedef enum logic [2:0] {
    MCX_ST_IDLE  = 3'b001,
    MCX_ST_FETCH = 3'b010,
    MCX_ST_EXEC  = 3'b100
  } mcx_state_e;

  mcx_pkg::mcx_dec_s dec;

  mcx_decode u_decode (
    .clk_sys      (clk_sys),
    .rst_b        (rst_b),
    .op_in        (op_in),
    .src_in       (src_in),
    .watchdog_sel (watchdog_sel),
    .dec_out      (dec)
  );

  //////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] operand_addr(input mcx_pkg::mcx_src_e s, input logic [7:0] opc,
                                              input logic [7:0] b2, input logic [1:0] sd,
                                              input logic [7:0] xv, input logic [7:0] yv);
    logic [7:0] a;
    a = b2;
    if (s == mcx_pkg::MCX_SRC_IND) begin
      a = opc[mcx_pkg::IND_SEL_BIT] ? yv : xv;
    end else if (s == mcx_pkg::MCX_SRC_SD) begin
      a = mcx_pkg::ADDR_X | {6'h00, sd};
    end
    return a;
  endfunction

  mcx_state_e          st_reg, st_next;
  logic [7:0]          acc_reg, acc_next;
  logic                z_reg, z_next, c_reg, c_next;
  logic [11:0]         pc_reg, pc_nx;
  mcx_pkg::mcx_dreq_s  dreq_reg, dreq_next;
  logic [2:0]          cnt_reg, cnt_next;
  logic                push_reg, push_next, pop_reg, pop_next;
  logic                wait_reg, wait_next, stop_reg, stop_next, done_reg, done_next;
  logic [7:0]          opc_reg, opc_next, b2_reg, b2_next, b3_reg, b3_next;

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [8:0]  sum;
    logic [7:0]  oper;
    logic [7:0]  res;
    logic        take;
    logic        tbit;
    logic [11:0] base;
    sum       = 9'h000;
    oper      = 8'h00;
    res       = 8'h00;
    take      = 1'b0;
    tbit      = 1'b0;
    base      = 12'h000;
    st_next   = st_reg;
    acc_next  = acc_reg;
    z_next    = z_reg;
    c_next    = c_reg;
    pc_nx     = pc_reg;
    dreq_next = dreq_reg;
    cnt_next  = cnt_reg;
    push_next = 1'b0;
    pop_next  = 1'b0;
    wait_next = 1'b0;
    stop_next = 1'b0;
    done_next = 1'b0;
    opc_next  = opc_reg;
    b2_next   = b2_reg;
    b3_next   = b3_reg;
    case (st_reg)
      MCX_ST_IDLE: begin
        if (start) begin
          opc_next  = opcode;
          b2_next   = byte2;
          b3_next   = byte3;
          pc_nx     = pc_in;
          dreq_next = '{rd: 1'b0, wr: 1'b0, addr: operand_addr(src_in, opcode, byte2, sd_sel, x_val, y_val),
                        wdata: 8'h00};
          st_next   = MCX_ST_FETCH;
        end
      end
      MCX_ST_FETCH: begin
        // decoder output is valid now; memory read issued for data operands
        dreq_next.rd = (dec.src != mcx_pkg::MCX_SRC_NONE && dec.src != mcx_pkg::MCX_SRC_IMM &&
                        dec.src != mcx_pkg::MCX_SRC_ACC);
        cnt_next     = dec.cycles - 3'h2;
        st_next      = MCX_ST_EXEC;
      end
      MCX_ST_EXEC: begin
        dreq_next.rd = 1'b0;
        dreq_next.wr = 1'b0;
        if (cnt_reg != 3'h0) begin
          // hold until the documented cycle count has elapsed
          cnt_next = cnt_reg - 3'h1;
        end else begin
          oper = (dec.src == mcx_pkg::MCX_SRC_IMM) ? b2_reg : mem_rdata;
          base = pc_reg + {10'h000, dec.nbytes};
          pc_nx = base;
          case (dec.op)
            mcx_pkg::MCX_OP_ADD: begin
              sum = {1'b0, acc_reg} + {1'b0, oper};
              acc_next = sum[7:0];
              z_next = (sum[7:0] == 8'h00);
              c_next = sum[8];
            end
            mcx_pkg::MCX_OP_SUB, mcx_pkg::MCX_OP_CMP: begin
              sum = {1'b0, acc_reg} - {1'b0, oper};
              if (dec.op == mcx_pkg::MCX_OP_SUB) begin
                acc_next = sum[7:0];
              end
              z_next = (sum[7:0] == 8'h00);
              c_next = sum[8];
            end
            mcx_pkg::MCX_OP_AND: begin
              res = acc_reg & oper;
              acc_next = res;
              z_next = (res == 8'h00);
              c_next = 1'b0;
            end
            mcx_pkg::MCX_OP_CLR: begin
              if (dec.src == mcx_pkg::MCX_SRC_ACC) begin
                acc_next = 8'h00;
                z_next = 1'b1;
                c_next = 1'b0;
              end else begin
                dreq_next.wr = 1'b1;
                dreq_next.wdata = 8'h00;
              end
            end
            mcx_pkg::MCX_OP_INC, mcx_pkg::MCX_OP_DEC: begin
              res = (dec.src == mcx_pkg::MCX_SRC_ACC) ? acc_reg : oper;
              res = (dec.op == mcx_pkg::MCX_OP_INC) ? res + 8'h01 : res - 8'h01;
              z_next = (res == 8'h00);
              if (dec.src == mcx_pkg::MCX_SRC_ACC) begin
                acc_next = res;
              end else begin
                dreq_next.wr = 1'b1;
                dreq_next.wdata = res;
              end
            end
            mcx_pkg::MCX_OP_COM: begin
              res = ~acc_reg;
              acc_next = res;
              z_next = (res == 8'h00);
              c_next = acc_reg[7];
            end
            mcx_pkg::MCX_OP_RLC, mcx_pkg::MCX_OP_SLA: begin
              res = {acc_reg[6:0], (dec.op == mcx_pkg::MCX_OP_RLC) ? c_reg : 1'b0};
              acc_next = res;
              z_next = (res == 8'h00);
              c_next = acc_reg[7];
            end
            mcx_pkg::MCX_OP_BR_C, mcx_pkg::MCX_OP_BR_NC, mcx_pkg::MCX_OP_BR_Z, mcx_pkg::MCX_OP_BR_NZ: begin
              case (dec.op)
                mcx_pkg::MCX_OP_BR_C:  take = c_reg;
                mcx_pkg::MCX_OP_BR_NC: take = ~c_reg;
                mcx_pkg::MCX_OP_BR_Z:  take = z_reg;
                default:               take = ~z_reg;
              endcase
              // bit 4 set means backward; nibble is the span, forward span counts from next byte
              if (take) begin
                pc_nx = opc_reg[4] ? pc_reg - {8'h00, opc_reg[3:0]}
                                   : pc_reg + {8'h00, opc_reg[3:0]} + 12'h001;
              end
            end
            mcx_pkg::MCX_OP_BT_CLR, mcx_pkg::MCX_OP_BT_SET: begin
              tbit = mem_rdata[opc_reg[7:5]];
              c_next = tbit;
              take = (dec.op == mcx_pkg::MCX_OP_BT_SET) ? tbit : ~tbit;
              if (take) begin
                // displacement counts from the third byte
                pc_nx = pc_reg + 12'h002 + {{4{b3_reg[7]}}, b3_reg};
              end
            end
            mcx_pkg::MCX_OP_BSET, mcx_pkg::MCX_OP_BCLR: begin
              res = mem_rdata;
              res[opc_reg[7:5]] = (dec.op == mcx_pkg::MCX_OP_BSET);
              dreq_next.wr = 1'b1;
              dreq_next.wdata = res;
            end
            mcx_pkg::MCX_OP_JP, mcx_pkg::MCX_OP_CALL: begin
              pc_nx = {opc_reg[3:0], b2_reg};
              push_next = (dec.op == mcx_pkg::MCX_OP_CALL);
            end
            mcx_pkg::MCX_OP_RET: begin
              pop_next = 1'b1;
            end
            mcx_pkg::MCX_OP_RETURN_FROM_INTERRUPT: begin
              pop_next = 1'b1;
              z_next = return_from_interrupt_flags.z;
              c_next = return_from_interrupt_flags.c;
            end
            mcx_pkg::MCX_OP_STOP: begin
              stop_next = 1'b1;
            end
            mcx_pkg::MCX_OP_WAIT: begin
              wait_next = 1'b1;
            end
            default: begin
            end
          endcase
          done_next = 1'b1;
          st_next = MCX_ST_IDLE;
        end
      end
      default: begin
        st_next = MCX_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_reg   <= MCX_ST_IDLE;
      acc_reg  <= mcx_pkg::ACC_RST;
      z_reg    <= 1'b0;
      c_reg    <= 1'b0;
      pc_reg   <= mcx_pkg::PC_RST;
      dreq_reg <= '0;
      cnt_reg  <= 3'h0;
      push_reg <= 1'b0;
      pop_reg  <= 1'b0;
      wait_reg <= 1'b0;
      stop_reg <= 1'b0;
      done_reg <= 1'b0;
      opc_reg  <= 8'h00;
      b2_reg   <= 8'h00;
      b3_reg   <= 8'h00;
    end else begin
      st_reg   <= st_next;
      acc_reg  <= acc_next;
      z_reg    <= z_next;
      c_reg    <= c_next;
      pc_reg   <= pc_nx;
      dreq_reg <= dreq_next;
      cnt_reg  <= cnt_next;
      push_reg <= push_next;
      pop_reg  <= pop_next;
      wait_reg <= wait_next;
      stop_reg <= stop_next;
      done_reg <= done_next;
      opc_reg  <= opc_next;
      b2_reg   <= b2_next;
      b3_reg   <= b3_next;
    end
  end

  assign acc      = acc_reg;
  assign flag_z   = z_reg;
  assign flag_c   = c_reg;
  assign pc_next  = pc_reg;
  assign dreq     = dreq_reg;
  assign push_ret = push_reg;
  assign pop_ret  = pop_reg;
  assign wait_req = wait_reg;
  assign stop_req = stop_reg;
  assign done     = done_reg;
  assign dec_info = dec;

endmodule
`default_nettype wire

// ### verification/mcx_exec_monitor.sv
// checker: cycle counts, flag keeping and address relations of the executor
`timescale 1ns/1ps
`default_nettype none
module mcx_exec_monitor (
  input wire logic                clk_sys,
  input wire logic                rst_b,
  input wire logic                start,
  input wire mcx_pkg::mcx_op_e    op_in,
  input wire mcx_pkg::mcx_src_e   src_in,
  input wire logic [7:0]          opcode,
  input wire logic [7:0]          byte2,
  input wire logic [1:0]          sd_sel,
  input wire logic [7:0]          x_val,
  input wire logic [7:0]          y_val,
  input wire mcx_pkg::mcx_flags_s return_from_interrupt_flags,
  input wire logic                watchdog_sel,
  input wire logic                flag_z,
  input wire logic                flag_c,
  input wire logic [11:0]         pc_next,
  input wire mcx_pkg::mcx_dreq_s  dreq,
  input wire logic                wait_req,
  input wire logic                stop_req,
  input wire logic                done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic busy_reg;
  logic busy_next;
  logic tk;
  logic two;
  logic rel;
  logic bt;
  logic jmp;
  // the done cycle is idle again, so a start there is taken
  assign tk  = start && (!busy_reg || done);
  assign rel = op_in inside {[mcx_pkg::MCX_OP_BR_C:mcx_pkg::MCX_OP_BR_NZ]};
  assign bt  = op_in inside {mcx_pkg::MCX_OP_BT_CLR, mcx_pkg::MCX_OP_BT_SET};
  assign jmp = op_in inside {mcx_pkg::MCX_OP_JP, mcx_pkg::MCX_OP_CALL};
  assign two = rel || op_in inside {mcx_pkg::MCX_OP_NOP, [mcx_pkg::MCX_OP_RET:mcx_pkg::MCX_OP_WAIT]};
  always_comb busy_next = rst_b && (tk || (busy_reg && !done));
  always_ff @(posedge clk_sys) busy_reg <= busy_next;
  ////////////////////////////////////////////////////////////////////////
  // done is launched on the Nth edge after taking and sampled high one edge later
  sequence s_quiet4; !done [*4]; endsequence
  sequence s_quiet5; !done [*5]; endsequence
  property p_four_len; tk && !two && !bt |-> ##1 s_quiet4 ##1 done; endproperty
  a_four_len: assert property (p_four_len) else $error("four-cycle op length wrong");
  property p_two_len; tk && two |-> ##1 !done [*2] ##1 done; endproperty
  a_two_len: assert property (p_two_len) else $error("two-cycle op length wrong");
  property p_btb_len; tk && bt |-> ##1 s_quiet5 ##1 done; endproperty
  a_btb_len: assert property (p_btb_len) else $error("bit-test length wrong");
  property p_rel_keep; tk && rel |-> ##3 {flag_z, flag_c} == $past({flag_z, flag_c}, 3); endproperty
  a_rel_keep: assert property (p_rel_keep) else $error("short branch changed flags");
  property p_btb_zkeep; tk && bt |-> ##6 flag_z == $past(flag_z, 6); endproperty
  a_btb_zkeep: assert property (p_btb_zkeep) else $error("bit-test changed zero");
  property p_bit_keep;
    tk && (jmp || op_in inside {mcx_pkg::MCX_OP_BSET, mcx_pkg::MCX_OP_BCLR})
      |-> ##5 {flag_z, flag_c} == $past({flag_z, flag_c}, 5);
  endproperty
  a_bit_keep: assert property (p_bit_keep) else $error("bit op or jump changed flags");
  property p_jmp_tgt; tk && jmp |-> ##5 pc_next == {$past(opcode[3:0], 5), $past(byte2, 5)}; endproperty
  a_jmp_tgt: assert property (p_jmp_tgt) else $error("jump target wrong");
  property p_stop_wd;
    tk && op_in == mcx_pkg::MCX_OP_STOP
      |-> ##3 ($past(watchdog_sel, 3) ? (wait_req && !stop_req) : (stop_req && !wait_req));
  endproperty
  a_stop_wd: assert property (p_stop_wd) else $error("stop handling wrong");
  property p_return_from_interrupt; tk && op_in == mcx_pkg::MCX_OP_RETURN_FROM_INTERRUPT |-> ##3 {flag_z, flag_c} == $past(return_from_interrupt_flags, 3); endproperty
  a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("restored flags wrong");
  property p_ind_sel;
    tk && src_in == mcx_pkg::MCX_SRC_IND
      |-> ##2 dreq.rd && dreq.addr == ($past(opcode[4], 2) ? $past(y_val, 2) : $past(x_val, 2));
  endproperty
  a_ind_sel: assert property (p_ind_sel) else $error("indirect pointer wrong");
  property p_sd_addr; tk && src_in == mcx_pkg::MCX_SRC_SD |-> ##2 dreq.rd && dreq.addr == {6'h20, $past(sd_sel, 2)}; endproperty
  a_sd_addr: assert property (p_sd_addr) else $error("short-direct address wrong");
endmodule
bind mcx_exec mcx_exec_monitor u_mcx_exec_monitor (
  .clk_sys, .rst_b, .start, .op_in, .src_in, .opcode, .byte2, .sd_sel, .x_val, .y_val,
  .return_from_interrupt_flags, .watchdog_sel, .flag_z, .flag_c, .pc_next, .dreq, .wait_req, .stop_req, .done
);
`default_nettype wire

// ### verification/mcx_dmem.sv
// partner model: 256-byte data space answering the executor's requests
`timescale 1ns/1ps
`default_nettype none
module mcx_dmem (
  input  wire logic               clk_sys,
  input  wire mcx_pkg::mcx_dreq_s dreq,
  input  wire logic               done,
  output logic [7:0]              rdata
);
  logic [7:0] mem [256];
  // same fill as the bench copy; 80h..83h hold X, Y, V, W
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i * 7 + 3);
    rdata = 8'hA5;
  end
  // fixed one-cycle answer; after done the stale byte is inverted, not held
  always @(posedge clk_sys) begin
    if (dreq.rd) rdata <= mem[dreq.addr];
    else if (done) rdata <= ~rdata;
    if (dreq.wr) mem[dreq.addr] <= dreq.wdata;
  end
endmodule
`default_nettype wire

// ### verification/mcx_exec_tb.sv
// testbench: random instruction stream checked against a reference model
`timescale 1ns/1ps
`default_nettype none
module mcx_exec_tb;
  logic                clk_sys = 1'b0;
  logic                rst_b = 1'b0;
  logic                start = 1'b0;
  mcx_pkg::mcx_op_e    op_in = mcx_pkg::MCX_OP_NOP;
  mcx_pkg::mcx_src_e   src_in = mcx_pkg::MCX_SRC_NONE;
  logic [7:0]          opcode = 8'h00, byte2 = 8'h00, byte3 = 8'h00, x_val = 8'h00, y_val = 8'h00;
  logic [11:0]         pc_in = 12'h000;
  logic [1:0]          sd_sel = 2'h0;
  mcx_pkg::mcx_flags_s return_from_interrupt_flags = '0;
  logic                watchdog_sel = 1'b0;
  logic [7:0]          mem_rdata, acc;
  logic                flag_z, flag_c, push_ret, pop_ret, wait_req, stop_req, done;
  logic [11:0]         pc_next;
  mcx_pkg::mcx_dreq_s  dreq;
  mcx_pkg::mcx_dec_s   dec_info;
  int                  fail_count = 0, n_tests = 0;
  logic [7:0]          bm [256];
  logic [7:0]          ea = 8'h00;
  logic                ez = 1'b0, ec = 1'b0;
  always #2.5 clk_sys = ~clk_sys;
  mcx_exec u_mcx_exec (.clk_sys, .rst_b, .start, .op_in, .src_in, .opcode, .byte2, .byte3, .pc_in,
    .sd_sel, .x_val, .y_val, .mem_rdata, .return_from_interrupt_flags, .watchdog_sel, .acc, .flag_z, .flag_c,
    .pc_next, .dreq, .push_ret, .pop_ret, .wait_req, .stop_req, .done, .dec_info);
  mcx_dmem u_mcx_dmem (.clk_sys, .dreq, .done, .rdata(mem_rdata));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk1(string nm, logic e, logic s);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic chk8(string nm, logic [7:0] e, logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic chk12(string nm, logic [11:0] e, logic [11:0] s);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // entered at a falling edge; returns at the falling edge of the done cycle
  task automatic run(mcx_pkg::mcx_op_e op, mcx_pkg::mcx_src_e src);
    logic [7:0] o, b2, ad, m, v, r;
    logic [8:0] s;
    logic [11:0] p, np;
    logic [3:0] pl;
    logic wr, tk, ckpc;
    int n, cnt;
    o = 8'($urandom);
    b2 = 8'($urandom);
    p = 12'($urandom);
    op_in = op;
    src_in = src;
    opcode = o;
    byte2 = b2;
    byte3 = 8'($urandom);
    pc_in = p;
    sd_sel = 2'($urandom);
    return_from_interrupt_flags = 2'($urandom);
    watchdog_sel = 1'($urandom);
    x_val = bm[8'h80];
    y_val = bm[8'h81];
    start = 1'b1;
    ad = src == mcx_pkg::MCX_SRC_IND ? (o[4] ? y_val : x_val) : (src == mcx_pkg::MCX_SRC_SD ? {6'h20, sd_sel} : b2);
    m = src == mcx_pkg::MCX_SRC_IMM ? b2 : bm[ad];
    v = src == mcx_pkg::MCX_SRC_ACC ? ea : m;
    {wr, r, pl, n, ckpc, tk} = {1'b0, 8'h00, 4'h0, 4, 1'b1, 1'b0};
    np = p + ((src inside {mcx_pkg::MCX_SRC_IMM, mcx_pkg::MCX_SRC_DIR} || op == mcx_pkg::MCX_OP_SLA ||
      src == mcx_pkg::MCX_SRC_ACC && op inside {[mcx_pkg::MCX_OP_CLR:mcx_pkg::MCX_OP_INC]}) ? 12'h002 : 12'h001);
    case (op)
      mcx_pkg::MCX_OP_ADD: begin s = ea + m; {ec, ea} = s; end
      mcx_pkg::MCX_OP_AND: {ec, ea} = {1'b0, ea & m};
      mcx_pkg::MCX_OP_CMP: ec = ea < m;
      mcx_pkg::MCX_OP_SUB: {ec, ea} = {ea < m, ea - m};
      mcx_pkg::MCX_OP_CLR: if (src == mcx_pkg::MCX_SRC_ACC) {ec, ea} = 9'h000;
        else {wr, np} = {1'b1, p + 12'h003};
      mcx_pkg::MCX_OP_DEC, mcx_pkg::MCX_OP_INC: begin
        r = op == mcx_pkg::MCX_OP_INC ? v + 8'h01 : v - 8'h01;
        ez = r == 8'h00;
        if (src == mcx_pkg::MCX_SRC_ACC) ea = r;
        else wr = 1'b1;
      end
      mcx_pkg::MCX_OP_COM: {ec, ea} = {ea[7], ~ea};
      mcx_pkg::MCX_OP_RLC: {ec, ea} = {ea, ec};
      mcx_pkg::MCX_OP_SLA: {ec, ea} = {ea, 1'b0};
      mcx_pkg::MCX_OP_BT_CLR, mcx_pkg::MCX_OP_BT_SET: begin
        ec = m[o[7:5]];
        tk = (op == mcx_pkg::MCX_OP_BT_SET) == ec;
        {n, np} = {5, tk ? p + 12'h002 + {{4{byte3[7]}}, byte3} : p + 12'h003};
      end
      mcx_pkg::MCX_OP_BSET, mcx_pkg::MCX_OP_BCLR: begin
        r = m;
        r[o[7:5]] = op == mcx_pkg::MCX_OP_BSET;
        wr = 1'b1;
      end
      mcx_pkg::MCX_OP_JP, mcx_pkg::MCX_OP_CALL: {np, pl[3]} = {o[3:0], b2, op == mcx_pkg::MCX_OP_CALL};
      mcx_pkg::MCX_OP_RET: {n, ckpc, pl} = {2, 1'b0, 4'h4};
      mcx_pkg::MCX_OP_RETURN_FROM_INTERRUPT: {n, ckpc, pl, ez, ec} = {2, 1'b0, 4'h4, return_from_interrupt_flags};
      mcx_pkg::MCX_OP_STOP: {n, pl} = {2, watchdog_sel ? 4'h2 : 4'h1};
      mcx_pkg::MCX_OP_WAIT: {n, pl} = {2, 4'h2};
      mcx_pkg::MCX_OP_NOP: n = 2;
      default: begin
        n = 2;
        tk = op == mcx_pkg::MCX_OP_BR_C ? ec : op == mcx_pkg::MCX_OP_BR_NC ? !ec : op == mcx_pkg::MCX_OP_BR_Z ? ez : !ez;
        np = !tk ? p + 12'h001 : o[4] ? p - 12'(o[3:0]) : p + 12'h001 + o[3:0];
      end
    endcase
    if (op inside {[mcx_pkg::MCX_OP_ADD:mcx_pkg::MCX_OP_CLR], [mcx_pkg::MCX_OP_COM:mcx_pkg::MCX_OP_SLA]} && !wr)
      ez = op == mcx_pkg::MCX_OP_CMP ? ea == m : ea == 8'h00;
    @(negedge clk_sys);
    start = 1'b0;
    // op class and source stand until done: the decoder registers them every edge
    opcode = ~o;
    cnt = 0;
    while (done !== 1'b1 && cnt < 9) begin
      @(negedge clk_sys);
      cnt++;
      // a start while busy must be ignored
      if (cnt == 2 && n > 2) start = 1'($urandom_range(1));
      if (cnt == 3) start = 1'b0;
    end
    chk12("cycles", 12'(n), 12'(cnt));
    chk8("acc", ea, acc);
    chk1("zero", ez, flag_z);
    chk1("carry", ec, flag_c);
    if (ckpc) chk12("pc", np, pc_next);
    chk1("write", wr, dreq.wr);
    if (wr) chk8("addr", ad, dreq.addr);
    if (wr) chk8("wdata", r, dreq.wdata);
    chk8("pulses", {4'h0, pl}, {4'h0, push_ret, pop_ret, wait_req, stop_req});
    chk8("dec_cycles", 8'(n), 8'(dec_info.cycles));
    chk8("dec_op", 8'(watchdog_sel && op == mcx_pkg::MCX_OP_STOP ? mcx_pkg::MCX_OP_WAIT : op), 8'(dec_info.op));
    if (wr) bm[ad] = r;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    mcx_pkg::mcx_op_e op;
    mcx_pkg::mcx_src_e sr;
    int k;
    void'($urandom(55245));
    for (int i = 0; i < 256; i++) bm[i] = 8'(i * 7 + 3);
    repeat (12) @(negedge clk_sys);
    rst_b = 1'b1;
    chk8("acc", 8'h00, acc);
    chk12("pc", 12'h000, pc_next);
    chk1("zero", 1'b0, flag_z);
    chk1("done", 1'b0, done);
    $display("test reset done");
    for (int i = 0; i < 500; i++) begin
      op = mcx_pkg::mcx_op_e'($urandom_range(24));
      k = $urandom_range(3);
      sr = mcx_pkg::MCX_SRC_NONE;
      if (op inside {[mcx_pkg::MCX_OP_ADD:mcx_pkg::MCX_OP_SUB]})
        sr = k == 0 ? mcx_pkg::MCX_SRC_IMM : k == 1 ? mcx_pkg::MCX_SRC_DIR : mcx_pkg::MCX_SRC_IND;
      if (op inside {mcx_pkg::MCX_OP_INC, mcx_pkg::MCX_OP_DEC})
        sr = k == 0 ? mcx_pkg::MCX_SRC_ACC : k == 1 ? mcx_pkg::MCX_SRC_DIR : k == 2 ? mcx_pkg::MCX_SRC_IND : mcx_pkg::MCX_SRC_SD;
      if (op == mcx_pkg::MCX_OP_CLR) sr = k[0] ? mcx_pkg::MCX_SRC_ACC : mcx_pkg::MCX_SRC_DIR;
      if (op inside {[mcx_pkg::MCX_OP_COM:mcx_pkg::MCX_OP_SLA]}) sr = mcx_pkg::MCX_SRC_ACC;
      if (op inside {[mcx_pkg::MCX_OP_BT_CLR:mcx_pkg::MCX_OP_BCLR]}) sr = mcx_pkg::MCX_SRC_DIR;
      run(op, sr);
    end
    $display("test stream done");
    test_done();
  end
  initial begin
    #60000;
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
